// ---- core/ems_pkg.sv ----
// constants, register map and state type of the external memory strobe sequencer
// assumes one 40 MHz pclk domain and an APB master with 32-bit data
package ems_pkg;

  localparam int ADDR_W = 22;
  localparam int BA_W = 2;
  localparam int DATA_W = 16;
  localparam int LEN_W = 9;
  localparam int BURST_BEATS = 4;

  // one timing unit is two pclk periods
  localparam int PCLK_PERIOD_PS = 25000;
  localparam int UNIT_CYCLES = 2;
  localparam int WAIT_STEP_UNITS = 16;
  localparam int RELEASE_UNITS = 4;
  localparam int ADV_UNITS = 2;
  localparam int READ_GAP_UNITS = 1;

  // burst clock limits; each half period of burst_clk is one timing unit
  localparam int BCLK_MAX_MHZ = 66;
  localparam int BCLK_MIN_HALF_PS = 5050;
  localparam int BCLK_MIN_HALF_CYC = (BCLK_MIN_HALF_PS + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;
  localparam int BCLK_MIN_PERIOD_CYC =
    (1000000 + BCLK_MAX_MHZ * PCLK_PERIOD_PS - 1) / (BCLK_MAX_MHZ * PCLK_PERIOD_PS);
  localparam int BCLK_HALF_CYC = UNIT_CYCLES;
  localparam int BCLK_PERIOD_CYC = 2 * BCLK_HALF_CYC;
  localparam int PH_W = $clog2(BCLK_PERIOD_CYC);

  // programmable ranges in timing units, the wait limit in 16-unit wait steps
  localparam int TA_MAX = 4;
  localparam int SETUP_MAX = 16;
  localparam int STROBE_MAX = 64;
  localparam int HOLD_MAX = 8;
  localparam int WAIT_MAX = 256;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_RD_TIMING = 8'h00;
  localparam logic [7:0] OFS_WR_TIMING = 8'h04;
  localparam logic [7:0] OFS_WAIT_CFG = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_WDATA = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1C;
  localparam logic [7:0] OFS_BDATA = 8'h20;

  // field positions and widths
  localparam int SETUP_LSB = 0;
  localparam int SETUP_W = 5;
  localparam int STROBE_LSB = 8;
  localparam int STROBE_W = 7;
  localparam int HOLD_LSB = 16;
  localparam int HOLD_W = 4;
  localparam int TA_LSB = 24;
  localparam int TA_W = 3;
  localparam int LIMIT_LSB = 0;
  localparam int WAIT_EN_BIT = 16;
  localparam int BURST_EN_BIT = 17;
  localparam int BA_LSB = 22;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int ST_TIMEOUT_BIT = 1;
  localparam int ST_DONE_BIT = 2;

  // values after reset, in timing units, the wait limit in 16-unit wait steps
  localparam logic [LEN_W-1:0] RST_SETUP = 9'h002;
  localparam logic [LEN_W-1:0] RST_STROBE = 9'h008;
  localparam logic [LEN_W-1:0] RST_HOLD = 9'h002;
  localparam logic [LEN_W-1:0] RST_TA = 9'h002;
  localparam logic [LEN_W-1:0] RST_LIMIT = 9'h080;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_WAITING, ST_RELEASE, ST_HOLD, ST_TURN,
    ST_ADV, ST_ADV_HOLD, ST_BEAT
  } seq_state_t;

endpackage : ems_pkg

// ---- core/unit_timer.sv ----
// phase length counter: loads a length in timing units and flags its last pclk cycle
// assumes load lengths of at least one unit
`timescale 1ns/100ps
module unit_timer
  import ems_pkg::*;
#(
  parameter int W = LEN_W
) (
  input logic pclk,
  input logic presetn,
  input logic load,
  input logic [W-1:0] load_units,
  output logic last
);

  logic [W:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= (W+1)'(int'(load_units) * UNIT_CYCLES - 1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign last = (cnt_r == '0);

  a_unit_even: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> cnt_r[0] && !last) else $error("phase length not a whole unit");

endmodule : unit_timer

// ---- core/ems_sequencer.sv ----
// strobe sequencer for asynchronous sram/flash with an apb register slave
// assumes apb master on pclk, memory pins sampled synchronously to pclk
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps

module ems_sequencer
  import ems_pkg::*;
#(
  parameter int BEATS = BURST_BEATS
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] ext_addr,
  output logic [BA_W-1:0] byte_addr,
  output logic [DATA_W-1:0] ext_data_out,
  input logic [DATA_W-1:0] ext_data_in,
  output logic ext_data_oe_n,
  output logic chip_sel_n,
  output logic out_enable_n,
  output logic write_strobe_n,
  input logic ext_wait_in,
  output logic burst_clk,
  output logic addr_valid_n
);

  localparam int BI_W = (BEATS > 1) ? $clog2(BEATS) : 1;

  seq_state_t state_r, state_nxt;
  logic [LEN_W-1:0] rs_r, rst_r, rh_r, ta_r, ws_r, wst_r, wh_r, lim_r;
  logic wen_r, burst_r;
  logic [ADDR_W-1:0] addr_r;
  logic [BA_W-1:0] ba_r;
  logic [DATA_W-1:0] wdata_r, rdata_r;
  logic [DATA_W-1:0] bdata_r [BEATS];
  logic [BI_W-1:0] beat_r;
  logic wr_r, burst_acc_r, wait_seen_r, waited_r, timeout_r, done_r;
  logic [LEN_W-1:0] ewc_r;
  logic [PH_W-1:0] ph_r, ph_nxt;
  logic wr_en, start, cur_wr, busy, wait_hit, wait_over;
  logic clk_st, clk_st_nxt;
  logic t_load, t_last;
  logic [LEN_W-1:0] t_units;
  logic [7:0] boff;

  function automatic logic [LEN_W-1:0] fit(input logic [LEN_W-1:0] v, input int hi);
    if (v == '0) return LEN_W'(1);
    if (int'(v) > hi) return LEN_W'(hi);
    return v;
  endfunction : fit

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign busy = (state_r != ST_IDLE);
  assign start = wr_en && (paddr == OFS_CMD) && pwdata[CMD_START_BIT] && !busy;
  assign cur_wr = start ? pwdata[CMD_WRITE_BIT] : wr_r;
  // a wait that drops again before the strobe ends is still caught through wait_seen_r
  assign wait_hit = wen_r && (wait_seen_r || ext_wait_in);
  assign wait_over = (ewc_r + 1'b1) >= lim_r;
  assign clk_st = (state_r == ST_ADV_HOLD) || (state_r == ST_BEAT);
  assign clk_st_nxt = (state_nxt == ST_ADV_HOLD) || (state_nxt == ST_BEAT);
  assign ph_nxt = clk_st ? ph_r + 1'b1 : '0;

  // configuration and data registers; lengths are forced into their legal range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_r <= RST_SETUP;
      rst_r <= RST_STROBE;
      rh_r <= RST_HOLD;
      ta_r <= RST_TA;
      ws_r <= RST_SETUP;
      wst_r <= RST_STROBE;
      wh_r <= RST_HOLD;
      lim_r <= RST_LIMIT;
      wen_r <= 1'b0;
      burst_r <= 1'b0;
      addr_r <= '0;
      ba_r <= '0;
      wdata_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_RD_TIMING: begin
          rs_r <= fit(LEN_W'(pwdata[SETUP_LSB +: SETUP_W]), SETUP_MAX);
          rst_r <= fit(LEN_W'(pwdata[STROBE_LSB +: STROBE_W]), STROBE_MAX);
          rh_r <= fit(LEN_W'(pwdata[HOLD_LSB +: HOLD_W]), HOLD_MAX);
          ta_r <= fit(LEN_W'(pwdata[TA_LSB +: TA_W]), TA_MAX);
        end
        OFS_WR_TIMING: begin
          ws_r <= fit(LEN_W'(pwdata[SETUP_LSB +: SETUP_W]), SETUP_MAX);
          wst_r <= fit(LEN_W'(pwdata[STROBE_LSB +: STROBE_W]), STROBE_MAX);
          wh_r <= fit(LEN_W'(pwdata[HOLD_LSB +: HOLD_W]), HOLD_MAX);
        end
        OFS_WAIT_CFG: begin
          lim_r <= fit(pwdata[LIMIT_LSB +: LEN_W], WAIT_MAX);
          wen_r <= pwdata[WAIT_EN_BIT];
          burst_r <= pwdata[BURST_EN_BIT];
        end
        OFS_ADDR: begin
          addr_r <= pwdata[ADDR_W-1:0];
          ba_r <= pwdata[BA_LSB +: BA_W];
        end
        OFS_WDATA: wdata_r <= pwdata[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  // phase order; each timed phase but waiting leaves when its timer expires; waiting leaves as soon as ext_wait_in falls, or at a step end once the limit is hit
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start) state_nxt = (burst_r && !cur_wr) ? ST_ADV : ST_SETUP;
      ST_SETUP: if (t_last) state_nxt = ST_STROBE;
      ST_STROBE: if (t_last) state_nxt = wait_hit ? ST_WAITING : ST_HOLD;
      ST_WAITING: begin
        if (!ext_wait_in) state_nxt = ST_RELEASE;
        else if (t_last && wait_over) state_nxt = ST_RELEASE;
      end
      ST_RELEASE: if (t_last) state_nxt = ST_HOLD;
      ST_HOLD: if (t_last) state_nxt = ST_TURN;
      ST_TURN: if (t_last) state_nxt = ST_IDLE;
      ST_ADV: if (t_last) state_nxt = ST_ADV_HOLD;
      ST_ADV_HOLD: if (t_last) state_nxt = ST_BEAT;
      ST_BEAT: if (t_last) state_nxt = ST_TURN;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // length of the phase being entered, in units
  always_comb begin
    t_units = LEN_W'(1);
    case (state_nxt)
      ST_SETUP: t_units = (cur_wr ? ws_r : rs_r) + 1'b1;
      ST_STROBE: t_units = cur_wr ? wst_r + 1'b1 : rst_r;
      ST_WAITING: t_units = LEN_W'(WAIT_STEP_UNITS);
      ST_RELEASE: t_units = LEN_W'(RELEASE_UNITS);
      ST_HOLD: t_units = (cur_wr ? wh_r : rh_r) + 1'b1;
      ST_TURN: t_units = cur_wr ? ta_r + 1'b1 : LEN_W'(READ_GAP_UNITS);
      ST_ADV: t_units = LEN_W'(ADV_UNITS);
      ST_ADV_HOLD: t_units = LEN_W'(ADV_UNITS);
      ST_BEAT: t_units = LEN_W'(2 * BEATS);
      default: t_units = LEN_W'(1);
    endcase
  end

  // a new 16-unit wait step starts while ext_wait_in stays high
  assign t_load = (state_nxt != state_r) || (state_r == ST_WAITING && t_last);

  unit_timer #(.W(LEN_W)) phase_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(t_load),
    .load_units(t_units),
    .last(t_last)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      wr_r <= 1'b0;
      burst_acc_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        wr_r <= cur_wr;
        burst_acc_r <= burst_r && !cur_wr;
      end
    end
  end

  // wait tracking: wait_seen_r sampled in strobe only, ewc_r counted in the waiting phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_seen_r <= 1'b0;
      waited_r <= 1'b0;
      ewc_r <= '0;
    end else begin
      if (state_r == ST_STROBE && wen_r && ext_wait_in) wait_seen_r <= 1'b1;
      else if (state_r != ST_STROBE) wait_seen_r <= 1'b0;
      if (start) begin
        waited_r <= 1'b0;
        ewc_r <= '0;
      end else begin
        if (state_nxt == ST_WAITING) waited_r <= 1'b1;
        if (state_r == ST_WAITING && ext_wait_in && t_last) ewc_r <= ewc_r + 1'b1;
      end
    end
  end

  // sticky status; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (state_r == ST_WAITING && ext_wait_in && t_last && wait_over) timeout_r <= 1'b1;
      else if (wr_en && paddr == OFS_STATUS && pwdata[ST_TIMEOUT_BIT]) timeout_r <= 1'b0;
      if (state_r == ST_TURN && t_last) done_r <= 1'b1;
      else if (wr_en && paddr == OFS_STATUS && pwdata[ST_DONE_BIT]) done_r <= 1'b0;
    end
  end

  // memory pins follow the state being entered, so each stands for its whole phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_sel_n <= 1'b1;
      out_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      addr_valid_n <= 1'b1;
      ext_data_oe_n <= 1'b1;
      ext_addr <= '0;
      byte_addr <= '0;
      ext_data_out <= '0;
    end else begin
      chip_sel_n <= (state_nxt == ST_IDLE) || (state_nxt == ST_TURN);
      out_enable_n <= !(!cur_wr && (state_nxt inside {ST_STROBE, ST_WAITING, ST_RELEASE,
                                                      ST_BEAT}));
      write_strobe_n <= !(cur_wr && (state_nxt inside {ST_STROBE, ST_WAITING,
                                                       ST_RELEASE}));
      addr_valid_n <= !(state_nxt inside {ST_ADV, ST_ADV_HOLD});
      ext_data_oe_n <= !(cur_wr && (state_nxt inside {ST_SETUP, ST_STROBE, ST_WAITING,
                                                      ST_RELEASE, ST_HOLD}));
      if (start) begin
        ext_addr <= addr_r;
        byte_addr <= ba_r;
        ext_data_out <= wdata_r;
      end
    end
  end

  // read capture at the end of the strobe, burst capture in the last pclk cycle of each burst_clk period of the beat phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
      beat_r <= '0;
      ph_r <= '0;
      burst_clk <= 1'b0;
      for (int i = 0; i < BEATS; i++) bdata_r[i] <= '0;
    end else begin
      if (!wr_r && state_nxt == ST_HOLD && state_r != ST_HOLD) rdata_r <= ext_data_in;
      ph_r <= clk_st_nxt ? ph_nxt : '0;
      burst_clk <= clk_st_nxt && (int'(ph_nxt) < BCLK_HALF_CYC);
      if (start) beat_r <= '0;
      else if (state_r == ST_BEAT && int'(ph_r) == BCLK_PERIOD_CYC - 1) begin
        bdata_r[beat_r] <= ext_data_in;
        beat_r <= beat_r + 1'b1;
      end
    end
  end

  // apb read data is prepared in the setup phase, so no wait state is needed
  assign boff = paddr - OFS_BDATA;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= '0;
      if (paddr >= OFS_BDATA && int'(boff[7:2]) < BEATS && boff[1:0] == 2'b00) begin
        prdata <= 32'(bdata_r[boff[2 +: BI_W]]);
      end else begin
        case (paddr)
          OFS_RD_TIMING: prdata <= {5'h00, ta_r[TA_W-1:0], 4'h0, rh_r[HOLD_W-1:0], 1'b0,
                                    rst_r[STROBE_W-1:0], 3'h0, rs_r[SETUP_W-1:0]};
          OFS_WR_TIMING: prdata <= {12'h000, wh_r[HOLD_W-1:0], 1'b0, wst_r[STROBE_W-1:0],
                                    3'h0, ws_r[SETUP_W-1:0]};
          OFS_WAIT_CFG: prdata <= {14'h0000, burst_r, wen_r, 7'h00, lim_r};
          OFS_ADDR: prdata <= {8'h00, ba_r, addr_r};
          OFS_WDATA: prdata <= {16'h0000, wdata_r};
          OFS_CMD: prdata <= {30'h0000_0000, wr_r, busy};
          OFS_STATUS: prdata <= {15'h0000, ewc_r, 5'h00, done_r, timeout_r, busy};
          OFS_RDATA: prdata <= {16'h0000, rdata_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // checking helpers: cycles since start, and cycles a strobe has been low
  logic [15:0] acc_cnt_r, strb_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_cnt_r <= '0;
      strb_cnt_r <= '0;
    end else begin
      acc_cnt_r <= start ? 16'h0001 : (busy ? acc_cnt_r + 1'b1 : acc_cnt_r);
      strb_cnt_r <= (out_enable_n && write_strobe_n) ? '0 : strb_cnt_r + 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_strobe_low_release;
    (!out_enable_n || !write_strobe_n)[*8];
  endsequence
  sequence s_adv_lead;
    (!addr_valid_n && !burst_clk)[*4];
  endsequence
  sequence s_adv_trail;
    (!addr_valid_n)[*4] ##1 addr_valid_n;
  endsequence

  a_len_range: assert property (rs_r inside {[1:16]} && ws_r inside {[1:16]} &&
    rst_r inside {[1:64]} && wst_r inside {[1:64]} && rh_r inside {[1:8]} &&
    wh_r inside {[1:8]} && ta_r inside {[1:4]} && lim_r inside {[1:256]})
    else $error("programmed length out of range");
  a_read_setup: assert property ($fell(out_enable_n) && !burst_acc_r |->
    acc_cnt_r == 16'(UNIT_CYCLES * (int'(rs_r) + 1) + 1)) else $error("read setup length wrong");
  a_oe_width: assert property ($rose(out_enable_n) && !waited_r && !burst_acc_r |->
    strb_cnt_r == 16'(UNIT_CYCLES * int'(rst_r))) else $error("read strobe width wrong");
  a_wait_release: assert property (state_r == ST_WAITING && !ext_wait_in |=>
    s_strobe_low_release ##1 (out_enable_n && write_strobe_n)) else $error("strobe not ended");
  a_wait_limit: assert property (ewc_r <= lim_r) else $error("wait count passed limit");
  a_write_total: assert property (state_r == ST_TURN && t_last && wr_r && !waited_r |->
    acc_cnt_r == 16'(UNIT_CYCLES * (int'(ws_r + wst_r + wh_r + ta_r) + 4)))
    else $error("write cycle length wrong");
  a_write_setup: assert property ($fell(write_strobe_n) |-> !chip_sel_n && !ext_data_oe_n &&
    acc_cnt_r == 16'(UNIT_CYCLES * (int'(ws_r) + 1) + 1)) else $error("write setup wrong");
  a_write_hold: assert property ($rose(write_strobe_n) |-> (!chip_sel_n && !ext_data_oe_n &&
    $stable(ext_addr) && $stable(ext_data_out))[*4]) else $error("write hold broken");
  a_we_width: assert property ($rose(write_strobe_n) && !waited_r |->
    strb_cnt_r == 16'(UNIT_CYCLES * (int'(wst_r) + 1))) else $error("write strobe width wrong");
  a_bclk_shape: assert property ($rose(burst_clk) |-> burst_clk[*2] ##1 !burst_clk[*2])
    else $error("burst clock half period too short");
  a_adv_window: assert property ($fell(addr_valid_n) |-> s_adv_lead ##1 burst_clk
    ##0 s_adv_trail) else $error("address valid window wrong");
  a_read_total: assert property (state_r == ST_TURN && t_last && !wr_r && !waited_r &&
    !burst_acc_r |-> acc_cnt_r == 16'(UNIT_CYCLES * (int'(rs_r + rst_r + rh_r) + 3)))
    else $error("read cycle length wrong");
  a_phase_order: assert property ($changed(state_r) && state_r == ST_HOLD |->
    $past(state_r) inside {ST_STROBE, ST_RELEASE}) else $error("hold entered out of order");
  a_wait_ignored: assert property (state_r == ST_STROBE && !wen_r |=>
    state_r != ST_WAITING) else $error("wait honoured while disabled");

endmodule : ems_sequencer

// ---- dv/ext_mem_model.sv ----
// far-side memory model: 16 words of async sram with burst read and a wait output
// assumes the sequencer registers every pin on pclk
`timescale 1ns/100ps
module ext_mem_model
  import ems_pkg::*;
(
  input logic pclk,
  input logic chip_sel_n,
  input logic out_enable_n,
  input logic write_strobe_n,
  input logic burst_clk,
  input logic ext_data_oe_n,
  input logic [ADDR_W-1:0] ext_addr,
  input logic [DATA_W-1:0] ext_data_out,
  input logic wait_req,
  input logic [11:0] wait_len,
  output logic [DATA_W-1:0] ext_data_in,
  output logic ext_wait_in
);
  logic [DATA_W-1:0] mem_r [16];
  logic [3:0] beat_r = '0;
  logic [11:0] wcnt_r = '0;
  logic st_q = 1'b1;
  logic we_q = 1'b1;
  logic bclk_q = 1'b0;
  wire st = out_enable_n & write_strobe_n;
  // the address-phase rise and the first beat rise come before any beat is sampled,
  // so the word after rise k is beat k-2 and each sample sees the word for its own beat
  wire [3:0] idx = ext_addr[3:0] + ((beat_r > 4'h1) ? beat_r - 4'h2 : 4'h0);

  initial begin
    ext_data_in = '0;
    ext_wait_in = 1'b0;
    foreach (mem_r[i]) mem_r[i] = {12'h5a0, 4'(i)};
  end

  always @(posedge pclk) begin
    we_q <= write_strobe_n;
    bclk_q <= burst_clk;
    // an undriven bus is captured as garbage, not as the right word
    if (!we_q && write_strobe_n && !chip_sel_n) begin
      mem_r[ext_addr[3:0]] <= ext_data_oe_n ? ~ext_data_out : ext_data_out;
    end
    if (chip_sel_n) begin
      beat_r <= '0;
    end else if (burst_clk && !bclk_q) begin
      beat_r <= beat_r + 4'h1;
    end
    // released bus toggles every cycle so a late sample cannot pass by luck
    if (!chip_sel_n && (!out_enable_n || beat_r != 4'h0)) begin
      ext_data_in <= mem_r[idx];
    end else begin
      ext_data_in <= ~ext_data_in;
    end
  end

  // wait rises as the strobe starts, well ahead of the hold phase
  always @(posedge pclk) begin
    st_q <= st;
    if (st_q && !st && wait_req) begin
      ext_wait_in <= 1'b1;
      wcnt_r <= wait_len;
    end else if (wcnt_r != 12'h000) begin
      wcnt_r <= wcnt_r - 12'h001;
      if (wcnt_r == 12'h001) ext_wait_in <= 1'b0;
    end
  end
endmodule : ext_mem_model

// ---- dv/test_async_ext_mem_sequencer.sv ----
// self-checking bench for the external memory strobe sequencer
// assumes the sequencer package and the memory model on the far side
`timescale 1ns/100ps
module test_async_ext_mem_sequencer import ems_pkg::*;;
  localparam int U = UNIT_CYCLES;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, wait_req, moved;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [ADDR_W-1:0] ext_addr;
  logic [BA_W-1:0] byte_addr;
  logic [DATA_W-1:0] ext_data_out, ext_data_in;
  logic ext_data_oe_n, chip_sel_n, out_enable_n, write_strobe_n, ext_wait_in, burst_clk;
  logic addr_valid_n, cs_q = 1, st_q = 1, wt_q = 0, av_q = 1, bc_q = 0;
  logic [11:0] wait_len;
  logic [39:0] pins_q;
  int fails = 0, n_checks = 0, cyc = 0, run = 0, t_bc = 0;
  int t_cs0, t_cs1, t_st0, t_st1, t_wd, t_av0, t_av1, hmin, lmin;
  wire strobe = out_enable_n & write_strobe_n;

  ems_sequencer ems_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_addr(ext_addr), .byte_addr(byte_addr),
    .ext_data_out(ext_data_out), .ext_data_in(ext_data_in), .ext_data_oe_n(ext_data_oe_n),
    .chip_sel_n(chip_sel_n), .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n),
    .ext_wait_in(ext_wait_in), .burst_clk(burst_clk), .addr_valid_n(addr_valid_n));
  ext_mem_model ext_mem_model_inst (.pclk(pclk), .chip_sel_n(chip_sel_n),
    .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n), .burst_clk(burst_clk),
    .ext_data_oe_n(ext_data_oe_n), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
    .wait_req(wait_req), .wait_len(wait_len), .ext_data_in(ext_data_in),
    .ext_wait_in(ext_wait_in));

  // pin edge timestamps in pclk cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    {cs_q, st_q, wt_q, av_q, bc_q} <= {chip_sel_n, strobe, ext_wait_in, addr_valid_n, burst_clk};
    pins_q <= {byte_addr, ext_addr, ext_data_out};
    if (cs_q && !chip_sel_n) t_cs0 <= cyc;
    if (!cs_q && chip_sel_n) t_cs1 <= cyc;
    if (st_q && !strobe) t_st0 <= cyc;
    if (!st_q && strobe) t_st1 <= cyc;
    if (wt_q && !ext_wait_in) t_wd <= cyc;
    if (av_q && !addr_valid_n) t_av0 <= cyc;
    if (!av_q && addr_valid_n) t_av1 <= cyc;
    if (!bc_q && burst_clk && t_bc <= t_av0) t_bc <= cyc;
    if (!cs_q && !chip_sel_n && pins_q != {byte_addr, ext_addr, ext_data_out}) moved <= 1;
    run <= (burst_clk == bc_q) ? run + 1 : 1;
    if (burst_clk != bc_q && bc_q && run < hmin) hmin <= run;
    if (burst_clk != bc_q && !bc_q && run < lmin) lmin <= run;
  end

  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // no cycle count is assumed here: a slave that never answers is ended by the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(0, a, 32'h0000_0000);
  endtask : rd

  task automatic acc(input logic w);
    int n;
    n = 0;
    moved = 0;
    hmin = 99;
    lmin = 99;
    wr(OFS_CMD, w ? 32'h0000_0003 : 32'h0000_0001);
    do rd(OFS_STATUS); while (q[0] !== 1'b0 && ++n < 2000);
    chk("finished", 0, q[0]);
    chk("done", 1, q[2]);
  endtask : acc

  task automatic t_regs;
    rd(OFS_RD_TIMING);
    chk("rd timing", 32'h0202_0802, q);
    wr(OFS_RD_TIMING, 32'h070f_7f00);
    rd(OFS_RD_TIMING);
    chk("clamped", 32'h0408_4001, q);
    rd(8'h3c);
    chk("unmapped", 32'h0000_0001, {q[30:0], e});
  endtask : t_regs

  task automatic t_write;
    wr(OFS_RD_TIMING, 32'h0301_0503);
    wr(OFS_WR_TIMING, 32'h0002_0301);
    wr(OFS_ADDR, 32'h0080_0005);
    wr(OFS_WDATA, 32'h0000_beef);
    wait_req <= 1;
    acc(1);
    chk("we setup", 2 * U, t_st0 - t_cs0);
    chk("we width", 4 * U, t_st1 - t_st0);
    chk("we hold", 3 * U, t_cs1 - t_st1);
    chk("pins held", 0, moved);
    chk("addr out", 32'h0080_0005, {8'h00, byte_addr, ext_addr});
  endtask : t_write

  task automatic t_read;
    acc(0);
    chk("oe setup", 4 * U, t_st0 - t_cs0);
    chk("oe width", 5 * U, t_st1 - t_st0);
    chk("oe hold", 2 * U, t_cs1 - t_st1);
    chk("cs span", 11 * U, t_cs1 - t_cs0);
    chk("pins held", 0, moved);
    rd(OFS_RDATA);
    chk("read data", 32'h0000_beef, q);
  endtask : t_read

  task automatic t_wait;
    wr(OFS_WAIT_CFG, 32'h0001_0004);
    wait_len <= 12'h064;
    acc(0);
    chk("release", 1, t_st1 - t_wd >= 4 * U && t_st1 - t_wd <= 4 * U + 2);
    rd(OFS_STATUS);
    chk("wait count", 32'h0000_0200, q & 32'h0001_ff02);
  endtask : t_wait

  task automatic t_burst;
    wr(OFS_WAIT_CFG, 32'h0002_0080);
    wr(OFS_ADDR, 32'h0000_0008);
    acc(0);
    chk("clk high", BCLK_HALF_CYC, hmin);
    chk("clk low", BCLK_HALF_CYC, lmin);
    chk("adv lead", ADV_UNITS * U, t_bc - t_av0);
    chk("adv hold", 1, t_av1 - t_bc >= ADV_UNITS * U);
    for (int i = 0; i < BURST_BEATS; i++) begin
      rd(OFS_BDATA + 8'(4 * i));
      chk("beat", {20'h0_05a0, 4'(8 + i)}, q);
    end
  endtask : t_burst

  task automatic t_tmo;
    wr(OFS_WAIT_CFG, 32'h0001_0001);
    wait_len <= 12'hfff;
    acc(0);
    rd(OFS_STATUS);
    chk("timeout", 32'h0000_0102, q & 32'h0001_ff02);
  endtask : t_tmo

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // a whole run is a few hundred cycles; 40000 leaves wide margin
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, wait_req} = '0;
    paddr = '0;
    pwdata = '0;
    wait_len = 12'h010;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_write();
    t_read();
    t_wait();
    t_burst();
    t_tmo();
    print_verdict();
  end
endmodule : test_async_ext_mem_sequencer
